// >>> mmrb_register_bank.v
// mmrb_register_bank.v: 16-bit register bank of a particle monitor as seen by a
// serial-link master. Assumes frame decoding lives outside and presents one register
// access at a time on the register port; test engine status arrives on clk.
//
// Notes on behaviour
// - every register is 16 bits wide, unsigned range 0 to FFFF.
// - negative quantities are two's complement; special classes read as -1, -2.
// - 32-bit values use two registers, lower number holds upper half.
// - bitmap bits are numbered from the least significant bit as zero.
// - arrays occupy consecutive registers; result code zero sits at register 56.
// - test label is 16 characters, two per register over 8 registers.
// - clock is 32-bit seconds since 1970, readable, writable, always counting.
// - test options reset with every bit cleared.
// - option bits 0-4: repeat, autostart, stop clean, log every, confirm.
// - option bits 5,6 reserved; bit 7 fake results; bit 8 no low-flow alarm.
// - writes to register 21 are not stored but decoded as commands.
// - codes 1 start, 2 recalc, 3-6 force relay one on/off, two on/off.
// - code 7 enters exercise mode flashing LED, toggling relays; 8 leaves.
// - code 9 aborts, 10 erases log, 11 seeks end, 12 seeks previous.
// - register 30 is read-only unit state enumeration.
// - register 31 read-only flags; bits 0-2 valid, new, log result.
// - flag bit 3 testing, bit 4 test complete.
// - flag bits 5-10 are alarms and drive relays per alarm mode.
// - flag bit 11 is set while under remote control over the link.
// - flag bits 12-14 mirror begin input and both relays; bit 15 unused.
// - answer the configured node address and always the permanent address 204.
// - register space spans 0 to 124; status read-only, settings read-write.
`timescale 1ns/10ps
`default_nettype none
`include "mmrb_defs.vh"

module mmrb_register_bank
#(
  parameter [27:0] TICK_CYCLES = `MMRB_TICK_CYCLES
)
(
  // clock and reset
  input  wire          clk,
  input  wire          resetn,
  // register port
  input  wire [6:0]    regAddr,
  input  wire          regWrEn,
  input  wire [15:0]   regWrData,
  input  wire          regRdEn,
  output reg  [15:0]   regRdData_ff,
  output reg           regRdValid_ff,
  // node address match
  input  wire          frameAddrValid,
  input  wire [7:0]    frameNodeAddr,
  output reg           nodeMatch_ff,
  // test engine status
  input  wire [15:0]   unitStateIn,
  input  wire          resultValid,
  input  wire          resultNew,
  input  wire          resultLog,
  input  wire          testActive,
  input  wire          testDone,
  input  wire [5:0]    alarmIn,
  input  wire [15:0]   heatIn,
  input  wire [127:0]  resultCodeIn,
  input  wire [255:0]  particleCountIn,
  // begin signal pin
  input  wire          beginInputPin,
  // settings toward the test engine
  output reg  [15:0]   testOptions_ff,
  output reg  [31:0]   testNumber_ff,
  // actions toward the test engine
  output wire          cmdStartTest,
  output wire          cmdRecalc,
  output wire          cmdStopTest,
  output wire          cmdLogErase,
  output wire          cmdLogSeekEnd,
  output wire          cmdLogSeekPrev,
  // outputs
  output reg           relayOneState_ff,
  output reg           relayTwoState_ff,
  output reg           ledFlash_ff,
  output wire [31:0]   clockSeconds
);

  // storage
  reg  [15:0] nodeAddr_ff;
  reg  [15:0] alarmMode_ff;
  reg  [15:0] labelMem_ff [0:7];
  reg  [1:0]  forceOne_ff;
  reg  [1:0]  forceTwo_ff;
  reg         exercise_ff;
  reg         exerPhase_ff;
  reg         remote_ff;
  reg  [3:0]  remoteSecs_ff;
  reg         beginMeta_ff;
  reg         beginSync_ff;

  // decoded access
  wire        inLabel  = (regAddr >= `MMRB_REG_LABEL_FIRST) && (regAddr <= `MMRB_REG_LABEL_LAST);
  wire        inCount  = (regAddr >= `MMRB_REG_COUNT_FIRST) && (regAddr <= `MMRB_REG_COUNT_LAST);
  wire        inResult = (regAddr >= `MMRB_REG_RESULT_FIRST) &&
                         (regAddr <= `MMRB_REG_RESULT_LAST);
  wire [6:0]  labelIdx  = regAddr - `MMRB_REG_LABEL_FIRST;
  wire [6:0]  countIdx  = regAddr - `MMRB_REG_COUNT_FIRST;
  wire [6:0]  resultIdx = regAddr - `MMRB_REG_RESULT_FIRST;
  wire        wrCommand = regWrEn && (regAddr == `MMRB_REG_COMMAND);
  wire        wrClockHi = regWrEn && (regAddr == `MMRB_REG_CLOCK_HI);
  wire        wrClockLo = regWrEn && (regAddr == `MMRB_REG_CLOCK_LO);

  wire [`MMRB_CMD_COUNT:1] cmdPulse;
  wire        secTick;
  wire [31:0] countWord  = particleCountIn[{countIdx[3:1], 5'h00} +: 32];
  wire [15:0] resultWord = resultCodeIn[{resultIdx[2:0], 4'h0} +: 16];

  mmrb_cmd_decode uCmd
  (
    .clk      (clk),
    .resetn   (resetn),
    .cmdWr    (wrCommand),
    .cmdCode  (regWrData),
    .cmdPulse (cmdPulse)
  );

  mmrb_rtc #(.TICK_CYCLES(TICK_CYCLES)) uRtc
  (
    .clk        (clk),
    .resetn     (resetn),
    .wrHi       (wrClockHi),
    .wrLo       (wrClockLo),
    .wrData     (regWrData),
    .secTick_ff (secTick),
    .seconds_ff (clockSeconds)
  );

  assign cmdStartTest   = cmdPulse[`MMRB_CMD_START];
  assign cmdRecalc      = cmdPulse[`MMRB_CMD_RECALC];
  assign cmdStopTest    = cmdPulse[`MMRB_CMD_STOP];
  assign cmdLogErase    = cmdPulse[`MMRB_CMD_LOG_ERASE];
  assign cmdLogSeekEnd  = cmdPulse[`MMRB_CMD_SEEK_END];
  assign cmdLogSeekPrev = cmdPulse[`MMRB_CMD_SEEK_PREV];

  // state flags, bit 0 is the least significant
  reg [15:0] flags;
  always @*
  begin
    flags = 16'h0000;
    flags[`MMRB_FLG_VALID]    = resultValid;
    flags[`MMRB_FLG_NEW]      = resultNew;
    flags[`MMRB_FLG_LOG]      = resultLog;
    flags[`MMRB_FLG_TESTING]  = testActive;
    flags[`MMRB_FLG_COMPLETE] = testDone;
    flags[`MMRB_FLG_ALARM_LSB +: 6] = alarmIn;
    flags[`MMRB_FLG_REMOTE]    = remote_ff;
    flags[`MMRB_FLG_BEGIN_IN]  = beginSync_ff;
    flags[`MMRB_FLG_RELAY_ONE] = relayOneState_ff;
    flags[`MMRB_FLG_RELAY_TWO] = relayTwoState_ff;
  end

  // read mux; command and unmapped numbers read as zero
  reg [15:0] nxt_rdData;
  always @*
  begin
    nxt_rdData = 16'h0000;
    if (inLabel)
      nxt_rdData = labelMem_ff[labelIdx[2:0]];
    else if (inCount)
      nxt_rdData = countIdx[0] ? countWord[15:0] : countWord[31:16];
    else if (inResult)
      nxt_rdData = resultWord;
    else
    begin
      case (regAddr)
        `MMRB_REG_NODE_ADDR:  nxt_rdData = nodeAddr_ff;
        `MMRB_REG_TESTNUM_HI: nxt_rdData = testNumber_ff[31:16];
        `MMRB_REG_TESTNUM_LO: nxt_rdData = testNumber_ff[15:0];
        `MMRB_REG_OPTIONS:    nxt_rdData = testOptions_ff;
        `MMRB_REG_CLOCK_HI:   nxt_rdData = clockSeconds[31:16];
        `MMRB_REG_CLOCK_LO:   nxt_rdData = clockSeconds[15:0];
        `MMRB_REG_ALARM_MODE: nxt_rdData = alarmMode_ff;
        `MMRB_REG_UNIT_STATE: nxt_rdData = unitStateIn;
        `MMRB_REG_FLAGS:      nxt_rdData = flags;
        `MMRB_REG_TEMP:       nxt_rdData = heatIn;
        default:              nxt_rdData = 16'h0000;
      endcase
    end
  end

  // automatic relay drive from the alarm flags
  wire alarmHigh = |alarmIn[2:0];
  wire alarmLow  = |alarmIn[5:3];
  reg  autoOne;
  reg  autoTwo;
  always @*
  begin
    case (alarmMode_ff)
      `MMRB_ALMMODE_SPLIT:
      begin
        autoOne = alarmHigh;
        autoTwo = alarmLow;
      end
      `MMRB_ALMMODE_ANY:
      begin
        autoOne = alarmHigh | alarmLow;
        autoTwo = alarmHigh | alarmLow;
      end
      default:
      begin
        autoOne = 1'b0;
        autoTwo = 1'b0;
      end
    endcase
  end

  integer k;
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      regRdData_ff   <= 16'h0000;
      regRdValid_ff  <= 1'b0;
      nodeMatch_ff   <= 1'b0;
      testOptions_ff <= `MMRB_OPTIONS_RST;
      testNumber_ff  <= `MMRB_TESTNUM_RST;
      nodeAddr_ff    <= `MMRB_NODE_ADDR_RST;
      alarmMode_ff   <= `MMRB_ALARM_MODE_RST;
      for (k = 0; k < 8; k = k + 1)
        labelMem_ff[k] <= `MMRB_LABEL_RST;
    end
    else
    begin
      regRdValid_ff <= regRdEn;
      if (regRdEn)
        regRdData_ff <= nxt_rdData;
      // a frame is ours on the configured address or the permanent one
      nodeMatch_ff <= frameAddrValid && ((frameNodeAddr == nodeAddr_ff[7:0]) ||
                      (frameNodeAddr == `MMRB_PERM_NODE));
      // only settings take writes; status and flag numbers fall through
      if (regWrEn)
      begin
        if (inLabel)
          labelMem_ff[labelIdx[2:0]] <= regWrData;
        case (regAddr)
          `MMRB_REG_NODE_ADDR:  nodeAddr_ff <= regWrData;
          `MMRB_REG_TESTNUM_HI: testNumber_ff[31:16] <= regWrData;
          `MMRB_REG_TESTNUM_LO: testNumber_ff[15:0] <= regWrData;
          // reserved option bits never store
          `MMRB_REG_OPTIONS:
            testOptions_ff <= regWrData & `MMRB_OPT_WR_MASK;
          `MMRB_REG_ALARM_MODE: alarmMode_ff <= regWrData;
          default:              ;
        endcase
      end
    end
  end

  // forced relays, exercise mode and relay outputs
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      forceOne_ff      <= 2'b00;
      forceTwo_ff      <= 2'b00;
      exercise_ff      <= 1'b0;
      exerPhase_ff     <= 1'b0;
      relayOneState_ff <= 1'b0;
      relayTwoState_ff <= 1'b0;
      ledFlash_ff      <= 1'b0;
    end
    else
    begin
      // a force holds until the next test start releases it
      if (cmdPulse[`MMRB_CMD_R1_ON])
        forceOne_ff <= 2'b11;
      else if (cmdPulse[`MMRB_CMD_R1_OFF])
        forceOne_ff <= 2'b10;
      else if (cmdPulse[`MMRB_CMD_START])
        forceOne_ff <= 2'b00;
      if (cmdPulse[`MMRB_CMD_R2_ON])
        forceTwo_ff <= 2'b11;
      else if (cmdPulse[`MMRB_CMD_R2_OFF])
        forceTwo_ff <= 2'b10;
      else if (cmdPulse[`MMRB_CMD_START])
        forceTwo_ff <= 2'b00;
      if (cmdPulse[`MMRB_CMD_EXER_ON])
        exercise_ff <= 1'b1;
      else if (cmdPulse[`MMRB_CMD_EXER_OFF])
        exercise_ff <= 1'b0;
      if (!exercise_ff)
        exerPhase_ff <= 1'b0;
      else if (secTick)
        exerPhase_ff <= ~exerPhase_ff;
      ledFlash_ff <= exercise_ff & exerPhase_ff;
      if (exercise_ff)
      begin
        relayOneState_ff <= exerPhase_ff;
        relayTwoState_ff <= ~exerPhase_ff;
      end
      else
      begin
        relayOneState_ff <= forceOne_ff[1] ? forceOne_ff[0] : autoOne;
        relayTwoState_ff <= forceTwo_ff[1] ? forceTwo_ff[0] : autoTwo;
      end
    end
  end

  // remote flag lingers a few seconds after the last access
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      remote_ff     <= 1'b0;
      remoteSecs_ff <= 4'h0;
    end
    else if (regWrEn || regRdEn)
    begin
      remote_ff     <= 1'b1;
      remoteSecs_ff <= 4'h0;
    end
    else if (remote_ff && secTick)
    begin
      if (remoteSecs_ff == `MMRB_REMOTE_HOLD_S - 4'h1)
        remote_ff <= 1'b0;
      remoteSecs_ff <= remoteSecs_ff + 4'h1;
    end
  end

  // begin pin is asynchronous to clk
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      beginMeta_ff <= 1'b0;
      beginSync_ff <= 1'b0;
    end
    else
    begin
      beginMeta_ff <= beginInputPin;
      beginSync_ff <= beginMeta_ff;
    end
  end

endmodule
`default_nettype wire

// >>> mmrb_defs.vh
// mmrb_defs.vh: register numbers, field positions, reset values and timing counts
// of the monitor register bank. Definitions only; included by every design file.
`ifndef MMRB_DEFS_VH
`define MMRB_DEFS_VH

// register numbers (word index on the register port)
`define MMRB_REG_NODE_ADDR   7'h06
`define MMRB_REG_TESTNUM_HI  7'h08
`define MMRB_REG_TESTNUM_LO  7'h09
`define MMRB_REG_LABEL_FIRST 7'h0A
`define MMRB_REG_LABEL_LAST  7'h11
`define MMRB_REG_OPTIONS     7'h14
`define MMRB_REG_COMMAND     7'h15
`define MMRB_REG_CLOCK_HI    7'h18
`define MMRB_REG_CLOCK_LO    7'h19
`define MMRB_REG_ALARM_MODE  7'h1A
`define MMRB_REG_UNIT_STATE  7'h1E
`define MMRB_REG_FLAGS       7'h1F
`define MMRB_REG_TEMP        7'h21
`define MMRB_REG_COUNT_FIRST 7'h28
`define MMRB_REG_COUNT_LAST  7'h37
`define MMRB_REG_RESULT_FIRST 7'h38
`define MMRB_REG_RESULT_LAST 7'h3F
`define MMRB_REG_LAST        7'h7C

// reset values
`define MMRB_OPTIONS_RST     16'h0000
`define MMRB_NODE_ADDR_RST   16'h0001
`define MMRB_ALARM_MODE_RST  16'h0001
`define MMRB_TESTNUM_RST     32'h00000000
`define MMRB_LABEL_RST       16'h0000
`define MMRB_CLOCK_RST       32'h00000000

// test option bit positions; bits 5 and 6 are reserved
`define MMRB_OPT_REPEAT      0
`define MMRB_OPT_AUTOSTART   1
`define MMRB_OPT_STOPCLEAN   2
`define MMRB_OPT_LOGEVERY    3
`define MMRB_OPT_CONFIRM     4
`define MMRB_OPT_FAKE        7
`define MMRB_OPT_LOWFLOW_OFF 8
`define MMRB_OPT_WR_MASK     16'h019F

// state flag bit positions
`define MMRB_FLG_VALID       0
`define MMRB_FLG_NEW         1
`define MMRB_FLG_LOG         2
`define MMRB_FLG_TESTING     3
`define MMRB_FLG_COMPLETE    4
`define MMRB_FLG_ALARM_LSB   5
`define MMRB_FLG_REMOTE      11
`define MMRB_FLG_BEGIN_IN    12
`define MMRB_FLG_RELAY_ONE   13
`define MMRB_FLG_RELAY_TWO   14

// command codes
`define MMRB_CMD_START       1
`define MMRB_CMD_RECALC      2
`define MMRB_CMD_R1_ON       3
`define MMRB_CMD_R1_OFF      4
`define MMRB_CMD_R2_ON       5
`define MMRB_CMD_R2_OFF      6
`define MMRB_CMD_EXER_ON     7
`define MMRB_CMD_EXER_OFF    8
`define MMRB_CMD_STOP        9
`define MMRB_CMD_LOG_ERASE   10
`define MMRB_CMD_SEEK_END    11
`define MMRB_CMD_SEEK_PREV   12
`define MMRB_CMD_COUNT       12

// alarm modes
`define MMRB_ALMMODE_OFF     16'h0000
`define MMRB_ALMMODE_SPLIT   16'h0001
`define MMRB_ALMMODE_ANY     16'h0002

// node addressing
`define MMRB_PERM_NODE       8'hCC

// timing
`define MMRB_CLK_MHZ         250
`define MMRB_RTC_PERIOD_S    1
// one second at MMRB_CLK_MHZ, sized for the 28-bit prescaler
`define MMRB_TICK_CYCLES     28'hEE6B280
`define MMRB_REMOTE_HOLD_S   4'h5

`endif

// >>> mmrb_cmd_decode.v
// mmrb_cmd_decode.v: turns a command register write into one-cycle action pulses.
// Assumes cmdWr is a single-cycle strobe in the clk domain.
`timescale 1ns/10ps
`default_nettype none
`include "mmrb_defs.vh"

module mmrb_cmd_decode
(
  // clock and reset
  input  wire                        clk,
  input  wire                        resetn,
  // command write
  input  wire                        cmdWr,
  input  wire [15:0]                 cmdCode,
  // decoded actions, bit n for code n
  output wire [`MMRB_CMD_COUNT:1]    cmdPulse
);

  genvar i;
  generate
    for (i = 1; i <= `MMRB_CMD_COUNT; i = i + 1)
    begin : gCode
      localparam [15:0] CODE = i;
      reg pulse_ff;
      // unknown codes simply match nothing
      always @(posedge clk)
      begin
        if (!resetn)
          pulse_ff <= 1'b0;
        else
          pulse_ff <= cmdWr && (cmdCode == CODE);
      end
      assign cmdPulse[i] = pulse_ff;
    end
  endgenerate

endmodule
`default_nettype wire

// >>> mmrb_rtc.v
// mmrb_rtc.v: seconds counter with its one-second prescaler.
// Assumes word writes come from the register port in the clk domain.
`timescale 1ns/10ps
`default_nettype none
`include "mmrb_defs.vh"

module mmrb_rtc
#(
  parameter [27:0] TICK_CYCLES = `MMRB_TICK_CYCLES
)
(
  // clock and reset
  input  wire        clk,
  input  wire        resetn,
  // word writes
  input  wire        wrHi,
  input  wire        wrLo,
  input  wire [15:0] wrData,
  // time
  output reg         secTick_ff,
  output reg  [31:0] seconds_ff
);

  localparam [27:0] TICK_LAST = TICK_CYCLES - 28'h0000001;

  reg  [27:0] presc_ff;
  reg  [31:0] nxt_seconds;
  wire        tick = (presc_ff == TICK_LAST);

  always @*
  begin
    nxt_seconds = seconds_ff + {31'h00000000, tick};
    if (wrHi)
      nxt_seconds[31:16] = wrData;
    if (wrLo)
      nxt_seconds[15:0] = wrData;
  end

  always @(posedge clk)
  begin
    if (!resetn)
    begin
      presc_ff   <= 28'h0000000;
      secTick_ff <= 1'b0;
      seconds_ff <= `MMRB_CLOCK_RST;
    end
    else
    begin
      // a low-word write restarts the second so the set value lasts a full one
      if (tick || wrLo)
        presc_ff <= 28'h0000000;
      else
        presc_ff <= presc_ff + 28'h0000001;
      secTick_ff <= tick;
      seconds_ff <= nxt_seconds;
    end
  end

endmodule
`default_nettype wire

// >>> mmrb_register_bank_assertions.sv
// mmrb_register_bank_assertions.sv: port-level checks of the register bank.
// Assumes a bind onto every mmrb_register_bank instance, one clock, sync reset.
`timescale 1ns/10ps
`default_nettype none
module mmrb_register_bank_checker
#(
  parameter [27:0] TICK_CYCLES = 28'h0000014
)
(
  // clock and reset
  input wire logic        clk,
  input wire logic        resetn,
  // register port
  input wire logic [6:0]  regAddr,
  input wire logic        regWrEn,
  input wire logic [15:0] regWrData,
  input wire logic        regRdEn,
  input wire logic [15:0] regRdData_ff,
  input wire logic        regRdValid_ff,
  // node match
  input wire logic        frameAddrValid,
  input wire logic [7:0]  frameNodeAddr,
  input wire logic        nodeMatch_ff,
  // status, settings and actions
  input wire logic [15:0] unitStateIn,
  input wire logic [15:0] testOptions_ff,
  input wire logic        cmdStartTest,
  input wire logic        cmdRecalc,
  input wire logic        cmdStopTest,
  input wire logic        cmdLogErase,
  input wire logic        cmdLogSeekEnd,
  input wire logic        cmdLogSeekPrev,
  input wire logic        relayOneState_ff,
  input wire logic        relayTwoState_ff
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  wire cmdWr = regWrEn && (regAddr == 7'h15);
  wire optWr = regWrEn && (regAddr == 7'h14);

  rd_valid_a: assert property (regRdEn |=> regRdValid_ff)
    else $error("read not answered one cycle later");
  rd_idle_a: assert property (!regRdEn |=> !regRdValid_ff)
    else $error("read valid without a read");
  cmd_start_a: assert property (cmdWr && regWrData == 16'h0001 |=> cmdStartTest)
    else $error("start code gave no start pulse");
  cmd_stop_a: assert property (cmdWr && regWrData == 16'h0009 |=> cmdStopTest && !cmdStartTest)
    else $error("stop code decoded wrongly");
  cmd_quiet_a: assert property (!cmdWr |=> !(cmdStartTest || cmdRecalc || cmdStopTest
    || cmdLogErase || cmdLogSeekEnd || cmdLogSeekPrev))
    else $error("action pulse without command write");
  opt_reset_a: assert property ($rose(resetn) |-> testOptions_ff == 16'h0000)
    else $error("options not cleared by reset");
  opt_write_a: assert property (optWr |=> testOptions_ff == (16'h019F & $past(regWrData)))
    else $error("options write stored wrong bits");
  opt_hold_a: assert property (!optWr |=> $stable(testOptions_ff))
    else $error("options changed without a write");
  state_read_a: assert property (regRdEn && regAddr == 7'h1E |=> regRdData_ff == $past(unitStateIn))
    else $error("unit state read wrong");
  flag_top_a: assert property (regRdEn && regAddr == 7'h1F |=> !regRdData_ff[15]
    && regRdData_ff[14:13] == $past({relayTwoState_ff, relayOneState_ff}))
    else $error("flag bits 13 to 15 wrong");
  node_perm_a: assert property (frameAddrValid && frameNodeAddr == 8'hCC |=> nodeMatch_ff)
    else $error("permanent node address not matched");
  node_idle_a: assert property (!frameAddrValid |=> !nodeMatch_ff)
    else $error("node match without a frame");
endmodule
bind mmrb_register_bank mmrb_register_bank_checker #(.TICK_CYCLES(TICK_CYCLES)) i_chk (.clk, .resetn,
  .regAddr, .regWrEn, .regWrData, .regRdEn, .regRdData_ff, .regRdValid_ff, .frameAddrValid,
  .frameNodeAddr, .nodeMatch_ff, .unitStateIn, .testOptions_ff, .cmdStartTest, .cmdRecalc,
  .cmdStopTest, .cmdLogErase, .cmdLogSeekEnd, .cmdLogSeekPrev, .relayOneState_ff,
  .relayTwoState_ff);
`default_nettype wire

// >>> mmrb_master_model.sv
// mmrb_master_model.sv: serial-link master as seen at the register port.
// Assumes tb calls its tasks; all changes land on the falling edge.
`timescale 1ns/10ps
`default_nettype none
module mmrb_master_model
(
  // clock
  input wire logic        clk,
  // register port
  output var logic [6:0]  regAddr,
  output var logic        regWrEn,
  output var logic [15:0] regWrData,
  output var logic        regRdEn,
  input wire logic [15:0] regRdData_ff,
  input wire logic        regRdValid_ff
);
  initial
  begin
    regAddr = 7'h00;
    regWrEn = 1'b0;
    regWrData = 16'h0000;
    regRdEn = 1'b0;
  end

  // released lines show the inverse so stale values never look valid
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(negedge clk);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge clk);
    regWrEn = 1'b0;
    regAddr = ~regAddr;
    regWrData = ~regWrData;
  endtask

  task automatic rd(input logic [6:0] a, output logic [15:0] d, output logic v);
    @(negedge clk);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge clk);
    regRdEn = 1'b0;
    regAddr = ~regAddr;
    v = regRdValid_ff;
    d = regRdData_ff;
  endtask

  // upper half goes to the lower register number
  task automatic wr32(input logic [6:0] a, input logic [31:0] d);
    wr(a, d[31:16]);
    wr(a + 7'h01, d[15:0]);
  endtask
endmodule
`default_nettype wire

// >>> tb.sv
// tb.sv: self-checking bench of the monitor register bank.
// Assumes the master model drives the register port; short second via TICK.
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam [27:0] TICK = 28'h0000014;
  logic         clk;
  logic         resetn;
  logic [6:0]   regAddr;
  logic         regWrEn;
  logic [15:0]  regWrData;
  logic         regRdEn;
  logic [15:0]  regRdData_ff;
  logic         regRdValid_ff;
  logic         frameAddrValid;
  logic [7:0]   frameNodeAddr;
  logic         nodeMatch_ff;
  logic [15:0]  unitStateIn;
  logic [4:0]   resFlags;
  logic [5:0]   alarmIn;
  logic [15:0]  heatIn;
  logic [127:0] resultCodeIn;
  logic [255:0] particleCountIn;
  logic         beginInputPin;
  logic [15:0]  testOptions_ff;
  logic [31:0]  testNumber_ff;
  wire  [5:0]   cmdVec;
  logic         relayOneState_ff;
  logic         relayTwoState_ff;
  logic         ledFlash_ff;
  logic [31:0]  clockSeconds;
  int           num_errors;
  int           cmp_count;

  mmrb_master_model i_master (.clk(clk), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData_ff(regRdData_ff),
    .regRdValid_ff(regRdValid_ff));

  mmrb_register_bank #(.TICK_CYCLES(TICK)) i_dut (.clk(clk), .resetn(resetn),
    .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
    .regRdData_ff(regRdData_ff), .regRdValid_ff(regRdValid_ff),
    .frameAddrValid(frameAddrValid), .frameNodeAddr(frameNodeAddr), .nodeMatch_ff(nodeMatch_ff),
    .unitStateIn(unitStateIn), .resultValid(resFlags[0]), .resultNew(resFlags[1]),
    .resultLog(resFlags[2]), .testActive(resFlags[3]), .testDone(resFlags[4]),
    .alarmIn(alarmIn), .heatIn(heatIn), .resultCodeIn(resultCodeIn),
    .particleCountIn(particleCountIn), .beginInputPin(beginInputPin),
    .testOptions_ff(testOptions_ff), .testNumber_ff(testNumber_ff), .cmdStartTest(cmdVec[0]),
    .cmdRecalc(cmdVec[1]), .cmdStopTest(cmdVec[2]), .cmdLogErase(cmdVec[3]),
    .cmdLogSeekEnd(cmdVec[4]), .cmdLogSeekPrev(cmdVec[5]),
    .relayOneState_ff(relayOneState_ff), .relayTwoState_ff(relayTwoState_ff),
    .ledFlash_ff(ledFlash_ff), .clockSeconds(clockSeconds));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic report_and_stop();
    if (num_errors == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic ran_out();
    num_errors++;
    $display("MISMATCH at %0t: wait ran out", $time);
    report_and_stop();
  endtask

  task automatic rdchk(input logic [6:0] a, input logic [15:0] e);
    logic [15:0] d;
    logic        v;
    i_master.rd(a, d, v);
    check(v, 1'b1);
    check(d, e);
  endtask

  task automatic node(input logic [7:0] a, input logic e);
    @(negedge clk);
    frameAddrValid = 1'b1;
    frameNodeAddr = a;
    @(negedge clk);
    check(nodeMatch_ff, e);
    frameAddrValid = 1'b0;
  endtask

  task automatic t_basic();
    rdchk(7'h14, 16'h0000);
    rdchk(7'h15, 16'h0000);
    i_master.wr(7'h7D, 16'hFFFF);
    rdchk(7'h7D, 16'h0000);
    i_master.wr(7'h14, 16'hFFFF);
    rdchk(7'h14, 16'h019F);
    unitStateIn = 16'hABCD;
    i_master.wr(7'h1E, 16'h1234);
    rdchk(7'h1E, 16'hABCD);
    i_master.wr32(7'h08, 32'h00012345);
    rdchk(7'h08, 16'h0001);
    rdchk(7'h09, 16'h2345);
    check(testNumber_ff, 32'h00012345);
  endtask

  task automatic t_node();
    node(8'hCC, 1'b1);
    node(8'h01, 1'b1);
    node(8'h05, 1'b0);
    i_master.wr(7'h06, 16'h0005);
    node(8'h05, 1'b1);
    node(8'h01, 1'b0);
  endtask

  task automatic t_arrays();
    @(negedge clk);
    resultCodeIn = {16'hFFFE, 96'h0, 16'hFFFF};
    heatIn = 16'hFF38;
    particleCountIn[63:32] = 32'h12345678;
    rdchk(7'h38, 16'hFFFF);
    rdchk(7'h3F, 16'hFFFE);
    rdchk(7'h21, 16'hFF38);
    rdchk(7'h2A, 16'h1234);
    rdchk(7'h2B, 16'h5678);
    i_master.wr(7'h38, 16'h0000);
    rdchk(7'h38, 16'hFFFF);
    i_master.wr(7'h0A, 16'h4142);
    i_master.wr(7'h11, 16'h5A59);
    rdchk(7'h0A, 16'h4142);
    rdchk(7'h0B, 16'h0000);
    rdchk(7'h11, 16'h5A59);
  endtask

  task automatic relays(input logic [5:0] al, input logic [1:0] e);
    @(negedge clk);
    alarmIn = al;
    repeat (4) @(negedge clk);
    check({relayTwoState_ff, relayOneState_ff}, e);
  endtask

  task automatic t_flags();
    @(negedge clk);
    resFlags = 5'b01101;
    beginInputPin = 1'b1;
    relays(6'h09, 2'b11);
    rdchk(7'h1F, 16'h792D);
    i_master.wr(7'h1A, 16'h0002);
    relays(6'h02, 2'b11);
    i_master.wr(7'h1A, 16'h0001);
    relays(6'h02, 2'b01);
    i_master.wr(7'h1A, 16'h0000);
    relays(6'h09, 2'b00);
    relays(6'h00, 2'b00);
  endtask

  task automatic t_clock();
    int n;
    i_master.wr32(7'h18, 32'h0001FFFF);
    rdchk(7'h18, 16'h0001);
    rdchk(7'h19, 16'hFFFF);
    n = 0;
    while (clockSeconds === 32'h0001FFFF && n < 40)
    begin
      @(negedge clk);
      n++;
    end
    if (n == 40)
      ran_out();
    check(clockSeconds, 32'h00020000);
    rdchk(7'h18, 16'h0002);
    rdchk(7'h19, 16'h0000);
  endtask

  task automatic t_cmds();
    logic [5:0] e;
    logic       l;
    int         n;
    for (int c = 0; c < 14; c++)
    begin
      i_master.wr(7'h15, c[15:0]);
      e = (c == 1) ? 6'h01 : (c == 2) ? 6'h02 : (c == 9) ? 6'h04 :
          (c == 10) ? 6'h08 : (c == 11) ? 6'h10 : (c == 12) ? 6'h20 : 6'h00;
      check(cmdVec, e);
      // relays and led settle two edges after the write edge
      repeat (2) @(negedge clk);
      if (c >= 3 && c <= 6)
        check({relayTwoState_ff, relayOneState_ff}, (c == 3) ? 2'b01 : (c == 5) ? 2'b10 : 2'b00);
      if (c == 7)
      begin
        check({relayTwoState_ff, ledFlash_ff}, {~relayOneState_ff, relayOneState_ff});
        l = ledFlash_ff;
        n = 0;
        // phase only moves on a second tick, so allow two of them
        while (ledFlash_ff === l && n < 40)
        begin
          @(negedge clk);
          n++;
        end
        if (n == 40)
          ran_out();
        check({relayTwoState_ff, ledFlash_ff}, {l, ~l});
      end
      if (c == 8)
        check({ledFlash_ff, relayTwoState_ff, relayOneState_ff}, 3'b000);
    end
  endtask

  initial
  begin
    num_errors = 0;
    cmp_count = 0;
    resetn = 1'b0;
    frameAddrValid = 1'b0;
    frameNodeAddr = 8'h00;
    unitStateIn = 16'h0000;
    resFlags = 5'b00000;
    alarmIn = 6'h00;
    heatIn = 16'h0000;
    resultCodeIn = 128'h0;
    particleCountIn = 256'h0;
    beginInputPin = 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    resetn = 1'b1;
    t_basic();
    t_node();
    t_arrays();
    t_flags();
    t_clock();
    t_cmds();
    report_and_stop();
  end
endmodule
`default_nettype wire
